// >>> bench/dpfc_host.sv
// serial host model driving the command pins of the power and fault control block
// assumes the block takes sdin on falling sclk and moves sdo on rising sclk
`timescale 1ns/100ps
module dpfc_host (
   // serial command pins
   output logic sclk_o,
   output logic sync_n_o,
   output logic sdin_o,
   // readback from the block
   input wire logic sdo_i,
   input wire logic sdo_oe_i
);
   // =====================================================================
   // idle levels
   // link clock rests high outside frames, so no stray edges reach the block
   initial begin
      sclk_o = 1'h1;
      sync_n_o = 1'h1;
      sdin_o = 1'h0;
   end

   // =====================================================================
   // one frame of nbits, msb first, 125 ns link clock period
   // rd collects sdo just before each fall, long after the previous rise
   task automatic xfer(input logic [23:0] word, input int nbits, output logic [23:0] rd);
      rd = 24'h0;
      sync_n_o = 1'h0;
      #62.5;
      for (int i = 0; i < nbits; i++) begin
         sdin_o = word[23 - i];
         #62.5;
         rd = {rd[22:0], sdo_oe_i & sdo_i}; // undriven sdo reads as zero
         sclk_o = 1'h0;
         #62.5;
         sclk_o = 1'h1;
      end
      #62.5;
      sync_n_o = 1'h1;
      // released data line flips so a stale bit never passes for data
      sdin_o = ~sdin_o;
      // gap far above the three clock minimum, also lets the word execute
      #500;
   endtask
endmodule

// >>> bench/tb_dpfc_ctrl.sv
// self-checking bench for the dac power and fault control block
// assumes a serial host model on the command pins and direct drive of the sensors
`timescale 1ns/100ps
module tb_dpfc_ctrl
   import dpfc_pkg::*;
   ;
   logic clk_sys_i, rst_i, overtemp_i, chan_a_overcurrent_i, chan_b_overcurrent_i;
   logic supplies_ok_i, bipolar_range_i, sclk, sync_n, sdin, sdo_o, sdo_oe_o;
   logic chan_a_power_on_o, chan_b_power_on_o, vref_power_on_o;
   logic chan_a_out_clamp_o, chan_b_out_clamp_o;
   logic thermal_alert_flag_o, chan_a_overcurrent_flag_o, chan_b_overcurrent_flag_o;
   dpfc_clr_t clear_level_o;
   int errors, checks_done;
   logic [23:0] rd;
   logic [15:0] rb;
   // status vector: pa pb ref clamp_a clamp_b thermal oc_a oc_b
   wire logic [7:0] st;
   assign st = {chan_a_power_on_o, chan_b_power_on_o, vref_power_on_o, chan_a_out_clamp_o,
                chan_b_out_clamp_o, thermal_alert_flag_o, chan_a_overcurrent_flag_o,
                chan_b_overcurrent_flag_o};

   // =====================================================================
   // clock, design and host
   initial begin
      clk_sys_i = 1'h0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   dpfc_ctrl u_dpfc_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sclk_i(sclk),
      .sync_n_i(sync_n), .sdin_i(sdin), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
      .overtemp_i(overtemp_i), .chan_a_overcurrent_i(chan_a_overcurrent_i),
      .chan_b_overcurrent_i(chan_b_overcurrent_i), .supplies_ok_i(supplies_ok_i),
      .bipolar_range_i(bipolar_range_i), .chan_a_power_on_o(chan_a_power_on_o),
      .chan_b_power_on_o(chan_b_power_on_o), .vref_power_on_o(vref_power_on_o),
      .chan_a_out_clamp_o(chan_a_out_clamp_o), .chan_b_out_clamp_o(chan_b_out_clamp_o),
      .clear_level_o(clear_level_o), .thermal_alert_flag_o(thermal_alert_flag_o),
      .chan_a_overcurrent_flag_o(chan_a_overcurrent_flag_o),
      .chan_b_overcurrent_flag_o(chan_b_overcurrent_flag_o));
   dpfc_host u_dpfc_host (.sclk_o(sclk), .sync_n_o(sync_n), .sdin_o(sdin),
      .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o));

   // =====================================================================
   // shared helpers
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // frames start 2.2 ns past an edge, so no host pin ever moves on a clock edge
   task automatic frame(input logic [23:0] w, input int n = 24);
      @(posedge clk_sys_i);
      #2.2;
      u_dpfc_host.xfer(w, n, rd);
   endtask
   // db6 always sent as zero by the host
   task automatic pwr(input logic [15:0] d);
      frame({8'h10, d & 16'hffbf});
   endtask
   task automatic ctrl(input logic [15:0] d);
      frame({8'h19, d});
   endtask
   // read request, then a nop frame that carries the answer out
   task automatic readback(output logic [15:0] v);
      frame(24'h900000);
      frame(24'h180000);
      v = rd[15:0];
   endtask
   // faults need about six clocks through the synchroniser and flops
   task automatic settle;
      repeat (12) @(posedge clk_sys_i);
   endtask

   // =====================================================================
   // scenarios
   task automatic t_reset;
      check("status after reset", st, 8'h18);
      check("clear level after reset", clear_level_o, DPFC_CLR_ZERO);
      check("sdo enable after reset", sdo_oe_o, 1'h0);
      // thermal shutdown disarmed by default, overtemp ignored
      @(posedge clk_sys_i);
      overtemp_i <= 1'h1;
      settle;
      check("unarmed overtemp", st, 8'h18);
      overtemp_i <= 1'h0;
      $display("test reset done");
   endtask

   task automatic t_power;
      pwr(16'h0015);
      check("power on all", st, 8'hf8);
      frame(24'h180000);
      frame(24'h100000, 23);
      check("nop and short frame ignored", st, 8'hf8);
      pwr(16'h02a0);
      check("alert bits not writable", st, 8'h18);
      readback(rb);
      check("readback zero", rb, 16'h0000);
      pwr(16'h0015);
      readback(rb);
      check("readback power", rb, 16'h0015);
      $display("test power done");
   endtask

   task automatic t_clamp;
      @(posedge clk_sys_i);
      supplies_ok_i <= 1'h1;
      settle;
      check("clamped before data", st, 8'hf8);
      repeat (1250) @(posedge clk_sys_i);
      frame(24'h008000);
      check("data a releases clamp a", st, 8'he8);
      frame(24'h028000);
      check("data b releases clamp b", st, 8'he0);
      @(posedge clk_sys_i);
      supplies_ok_i <= 1'h0;
      settle;
      check("brownout clamps", st, 8'hf8);
      supplies_ok_i <= 1'h1;
      settle;
      check("clamp held until data", st, 8'hf8);
      frame(24'h048000);
      pwr(16'h0011);
      check("powered down b grounded", st, 8'ha8);
      pwr(16'h0015);
      check("b restored", st, 8'he0);
      $display("test clamp done");
   endtask

   task automatic t_oc_clamp;
      @(posedge clk_sys_i);
      chan_a_overcurrent_i <= 1'h1;
      settle;
      check("clamp mode oc a", st, 8'he2);
      readback(rb);
      check("readback oc a", rb, 16'h0095);
      chan_a_overcurrent_i <= 1'h0;
      chan_b_overcurrent_i <= 1'h1;
      settle;
      check("clamp mode oc b", st, 8'he1);
      readback(rb);
      check("readback oc b", rb, 16'h0215);
      chan_b_overcurrent_i <= 1'h0;
      settle;
      check("oc flags self clear", st, 8'he0);
      $display("test overcurrent clamp done");
   endtask

   task automatic t_oc_down;
      ctrl(16'h0000);
      @(posedge clk_sys_i);
      chan_b_overcurrent_i <= 1'h1;
      settle;
      check("oc b powers down", st, 8'ha9);
      readback(rb);
      check("readback pu b cleared", rb, 16'h0211);
      chan_b_overcurrent_i <= 1'h0;
      settle;
      check("b stays down", st, 8'ha8);
      pwr(16'h0015);
      check("b back on rewrite", st, 8'he0);
      @(posedge clk_sys_i);
      chan_a_overcurrent_i <= 1'h1;
      settle;
      check("oc a powers down", st, 8'h72);
      chan_a_overcurrent_i <= 1'h0;
      pwr(16'h0015);
      check("a back on rewrite", st, 8'he0);
      $display("test overcurrent power-down done");
   endtask

   task automatic t_thermal;
      ctrl(16'h000c);
      @(posedge clk_sys_i);
      overtemp_i <= 1'h1;
      settle;
      check("armed overtemp", st & 8'hdf, 8'h1c);
      readback(rb);
      check("readback thermal", rb & 16'hffef, 16'h0020);
      overtemp_i <= 1'h0;
      settle;
      check("thermal flag drops", st & 8'hdf, 8'h18);
      $display("test thermal done");
   endtask

   task automatic t_clear;
      logic [1:0] exp;
      for (int k = 0; k < 4; k++) begin
         ctrl({14'h1, k[1], 1'h0});
         @(posedge clk_sys_i);
         bipolar_range_i <= k[0];
         settle;
         exp = !k[1] ? DPFC_CLR_ZERO : (k[0] ? DPFC_CLR_NEG_FULL : DPFC_CLR_MID);
         check("clear level", clear_level_o, exp);
      end
      $display("test clear select done");
   endtask

   // =====================================================================
   // verdict
   task automatic conclude;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // =====================================================================
   // main sequence; sensors driven with nba, at rising edges except right after a readback
   initial begin
      errors = 0;
      checks_done = 0;
      rst_i = 1'h1;
      overtemp_i = 1'h0;
      chan_a_overcurrent_i = 1'h0;
      chan_b_overcurrent_i = 1'h0;
      supplies_ok_i = 1'h0;
      bipolar_range_i = 1'h0;
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'h0;
      repeat (4) @(posedge clk_sys_i);
      t_reset;
      t_power;
      t_clamp;
      t_oc_clamp;
      t_oc_down;
      t_thermal;
      t_clear;
      conclude;
   end

   // watchdog, about four times the expected run length, well under the cycle budget
   initial begin
      #500us;
      errors++;
      $display("Error watchdog expected finish seen timeout");
      conclude;
   end
endmodule

// >>> design/dpfc_ctrl.sv
// power and fault control of a dual voltage output dac
// assumes serial pins and fault sensors arrive asynchronously; range from same clock
`timescale 1ns/100ps
`include "dpfc_regs.svh"
module dpfc_ctrl
   import dpfc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // serial command pins
   input wire logic sclk_i,
   input wire logic sync_n_i,
   input wire logic sdin_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   // fault sensors and supply monitor
   input wire logic overtemp_i,
   input wire logic chan_a_overcurrent_i,
   input wire logic chan_b_overcurrent_i,
   input wire logic supplies_ok_i,
   // range information
   input wire logic bipolar_range_i,
   // analog controls
   output logic chan_a_power_on_o,
   output logic chan_b_power_on_o,
   output logic vref_power_on_o,
   output logic chan_a_out_clamp_o,
   output logic chan_b_out_clamp_o,
   output dpfc_clr_t clear_level_o,
   // status
   output logic thermal_alert_flag_o,
   output logic chan_a_overcurrent_flag_o,
   output logic chan_b_overcurrent_flag_o
);
   // =====================================================================
   // input synchronisation
   dpfc_sync_if #(.WIDTH(7)) sif ();
   logic sclk_s, sync_n_s, sdin_s, ot_s, oc_a_s, oc_b_s, sup_s;
   // idle-high pins enter inverted, so the cleared filter reads idle, not a false frame
   assign sif.raw = {supplies_ok_i, chan_b_overcurrent_i, chan_a_overcurrent_i,
                     overtemp_i, sdin_i, ~sync_n_i, ~sclk_i};
   assign {sup_s, oc_b_s, oc_a_s, ot_s, sdin_s} = sif.clean[6:2];
   assign sync_n_s = ~sif.clean[1];
   assign sclk_s = ~sif.clean[0];

   dpfc_sync #(.WIDTH(7)) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .sif(sif)
   );

   // =====================================================================
   // serial frame receiver
   dpfc_state_t state;
   logic sclk_d;
   logic [4:0] bit_cnt;
   logic [23:0] shift;
   logic sclk_fall, sclk_rise;
   assign sclk_fall = sclk_d & ~sclk_s;
   assign sclk_rise = ~sclk_d & sclk_s;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_d <= 1'b1;
      end else begin
         sclk_d <= sclk_s;
      end
   end

   // data valid on the falling sclk edge
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state <= DPFC_IDLE;
         bit_cnt <= 5'h0;
         shift <= 24'h0;
      end else begin
         unique case (state)
            DPFC_IDLE: begin
               bit_cnt <= 5'h0;
               if (!sync_n_s) begin
                  state <= DPFC_SHIFT;
               end
            end
            DPFC_SHIFT: begin
               if (sync_n_s) begin
                  state <= DPFC_EXEC;
               end else if (sclk_fall) begin
                  shift <= {shift[22:0], sdin_s};
                  // saturate so overlong frames are rejected
                  if (bit_cnt != 5'h1f) begin
                     bit_cnt <= bit_cnt + 5'h1;
                  end
               end
            end
            DPFC_EXEC: begin
               state <= DPFC_IDLE;
            end
            default: begin
               state <= DPFC_IDLE;
            end
         endcase
      end
   end

   // a frame counts only with exactly one word in it
   logic exec_ok, wr_ok, rd_ok;
   logic [2:0] reg_sel, adr_sel;
   assign exec_ok = (state == DPFC_EXEC) && (bit_cnt == `DPFC_FRAME_BITS);
   assign wr_ok = exec_ok && !shift[`DPFC_RW_BIT];
   assign rd_ok = exec_ok && shift[`DPFC_RW_BIT];
   assign reg_sel = shift[`DPFC_REG_MSB:`DPFC_REG_LSB];
   assign adr_sel = shift[`DPFC_ADR_MSB:`DPFC_ADR_LSB];

   logic pwr_wr, ctl_wr, dac_wr_a, dac_wr_b;
   assign pwr_wr = wr_ok && (reg_sel == `DPFC_SEL_POWER);
   assign ctl_wr = wr_ok && (reg_sel == `DPFC_SEL_CTRL) && (adr_sel == `DPFC_ADR_CTRL_OPT);
   assign dac_wr_a = wr_ok && (reg_sel == `DPFC_SEL_DAC)
                     && (adr_sel == `DPFC_ADR_CHAN_A || adr_sel == `DPFC_ADR_BOTH);
   assign dac_wr_b = wr_ok && (reg_sel == `DPFC_SEL_DAC)
                     && (adr_sel == `DPFC_ADR_CHAN_B || adr_sel == `DPFC_ADR_BOTH);

   // =====================================================================
   // control options
   logic sdo_disable, clear_code_select, clamp_enable, thermal_shutdown_arm;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sdo_disable <= `DPFC_RST_OFF;
         clear_code_select <= `DPFC_RST_OFF;
         clamp_enable <= `DPFC_RST_CLAMP;
         thermal_shutdown_arm <= `DPFC_RST_OFF;
      end else if (ctl_wr) begin
         sdo_disable <= shift[`DPFC_CTL_SDO_DIS];
         clear_code_select <= shift[`DPFC_CTL_CLR_SEL];
         clamp_enable <= shift[`DPFC_CTL_CLAMP];
         thermal_shutdown_arm <= shift[`DPFC_CTL_TSD_ARM];
      end
   end

   // =====================================================================
   // fault conditions
   logic thermal_trip, oc_kill_a, oc_kill_b;
   assign thermal_trip = thermal_shutdown_arm && ot_s;
   assign oc_kill_a = !clamp_enable && oc_a_s;
   assign oc_kill_b = !clamp_enable && oc_b_s;

   // alert bits follow the condition; writes never reach them
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         thermal_alert_flag_o <= 1'b0;
         chan_a_overcurrent_flag_o <= 1'b0;
         chan_b_overcurrent_flag_o <= 1'b0;
      end else begin
         thermal_alert_flag_o <= thermal_trip;
         chan_a_overcurrent_flag_o <= oc_a_s;
         chan_b_overcurrent_flag_o <= oc_b_s;
      end
   end

   // =====================================================================
   // power-on bits; on channels a and b a fault wins over a host write in the same cycle, reference follows the write only
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         chan_a_power_on_o <= `DPFC_RST_OFF;
         chan_b_power_on_o <= `DPFC_RST_OFF;
         vref_power_on_o <= `DPFC_RST_OFF;
      end else begin
         if (thermal_trip || oc_kill_a) begin
            chan_a_power_on_o <= 1'b0;
         end else if (pwr_wr) begin
            chan_a_power_on_o <= shift[`DPFC_PWR_PU_A];
         end
         if (thermal_trip || oc_kill_b) begin
            chan_b_power_on_o <= 1'b0;
         end else if (pwr_wr) begin
            chan_b_power_on_o <= shift[`DPFC_PWR_PU_B];
         end
         if (pwr_wr) begin
            vref_power_on_o <= shift[`DPFC_PWR_VREF_POWER_ON];
         end
      end
   end

   // =====================================================================
   // output clamp: held until supplies settle and a data word lands
   logic valid_a, valid_b;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         valid_a <= 1'b0;
         valid_b <= 1'b0;
      end else if (!sup_s) begin
         // a brownout drops back to the clamped start state
         valid_a <= 1'b0;
         valid_b <= 1'b0;
      end else begin
         valid_a <= valid_a | dac_wr_a;
         valid_b <= valid_b | dac_wr_b;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         chan_a_out_clamp_o <= 1'b1;
         chan_b_out_clamp_o <= 1'b1;
      end else begin
         chan_a_out_clamp_o <= !valid_a || !chan_a_power_on_o;
         chan_b_out_clamp_o <= !valid_b || !chan_b_power_on_o;
      end
   end

   // =====================================================================
   // clear level from select setting and range
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         clear_level_o <= DPFC_CLR_ZERO;
      end else if (!clear_code_select) begin
         clear_level_o <= DPFC_CLR_ZERO;
      end else begin
         clear_level_o <= bipolar_range_i ? DPFC_CLR_NEG_FULL : DPFC_CLR_MID;
      end
   end

   // =====================================================================
   // readback of the power word, shifted out in the next frame
   logic [15:0] power_word;
   logic [23:0] sdo_sh;
   always_comb begin
      power_word = 16'h0;
      power_word[`DPFC_PWR_PU_A] = chan_a_power_on_o;
      power_word[`DPFC_PWR_PU_B] = chan_b_power_on_o;
      power_word[`DPFC_PWR_VREF_POWER_ON] = vref_power_on_o;
      power_word[`DPFC_PWR_TSD] = thermal_alert_flag_o;
      power_word[`DPFC_PWR_OC_A] = chan_a_overcurrent_flag_o;
      power_word[`DPFC_PWR_OC_B] = chan_b_overcurrent_flag_o;
   end

   // only the power word answers a read; other selects return zero data
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sdo_sh <= 24'h0;
      end else if (rd_ok) begin
         sdo_sh <= {shift[23:16], (reg_sel == `DPFC_SEL_POWER) ? power_word : 16'h0};
      end else if (state == DPFC_SHIFT && sclk_rise) begin
         sdo_sh <= {sdo_sh[22:0], 1'b0};
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sdo_o <= 1'b0;
         sdo_oe_o <= 1'b0;
      end else begin
         sdo_o <= sdo_sh[23];
         sdo_oe_o <= !sdo_disable && (state == DPFC_SHIFT);
      end
   end

   // =====================================================================
   // checks
   power_write_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      pwr_wr && !thermal_trip && !oc_kill_a |=> chan_a_power_on_o == $past(shift[`DPFC_PWR_PU_A]))
      else $error("power write did not reach channel a");
   oc_down_a_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      oc_kill_a |=> !chan_a_power_on_o ##1 chan_a_out_clamp_o)
      else $error("channel a stayed on after overcurrent");
   oc_down_b_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      oc_kill_b |=> !chan_b_power_on_o ##1 chan_b_out_clamp_o)
      else $error("channel b stayed on after overcurrent");
   thermal_down_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      thermal_trip |=> !chan_a_power_on_o && !chan_b_power_on_o && thermal_alert_flag_o)
      else $error("thermal trip did not shut channels");
   oca_flag_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(oc_a_s) |=> chan_a_overcurrent_flag_o)
      else $error("channel a overcurrent flag missed");
   ocb_flag_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $fell(oc_b_s) |=> !chan_b_overcurrent_flag_o)
      else $error("channel b overcurrent flag stuck");
   clear_pick_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      clear_code_select && bipolar_range_i && !ctl_wr |=> clear_level_o == DPFC_CLR_NEG_FULL)
      else $error("clear level wrong for bipolar range");
   clamp_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !valid_a |=> chan_a_out_clamp_o)
      else $error("channel a unclamped before valid data");
   clamp_keep_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      clamp_enable && oc_a_s && chan_a_power_on_o && !pwr_wr && !thermal_trip
      |=> chan_a_power_on_o)
      else $error("clamp mode powered channel a down");
   disarm_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !thermal_shutdown_arm && !ctl_wr |=> !thermal_alert_flag_o [*2])
      else $error("thermal alert while disarmed");

   power_frame_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) pwr_wr);
   read_frame_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) rd_ok);
   oc_kill_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
      chan_a_power_on_o && oc_kill_a);
   thermal_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) thermal_trip);
endmodule

// >>> design/dpfc_pkg.sv
// types shared by the dac power and fault control block
// assumes inclusion before every design file of the block
package dpfc_pkg;
   // =====================================================================
   // frame receiver states, gray along idle, shift, execute
   typedef enum logic [1:0] {
      DPFC_IDLE = 2'h0,
      DPFC_SHIFT = 2'h1,
      DPFC_EXEC = 2'h3
   } dpfc_state_t;

   // =====================================================================
   // level that the clear function drives
   typedef enum logic [1:0] {
      DPFC_CLR_ZERO = 2'h0,
      DPFC_CLR_MID = 2'h1,
      DPFC_CLR_NEG_FULL = 2'h2
   } dpfc_clr_t;
endpackage

// >>> design/dpfc_regs.svh
// constants of the dac power and fault control block
// assumes the serial command word layout of the dual dac, 24 bits, msb first
// Operation
// - register select 010 writes power control
// - channel a power bit db0, reset clear
// - channel b power bit db2, reset clear
// - unclamped overcurrent powers channel down, clears bit
// - reference power bit db4, reset clear
// - thermal alert db5 read-only, downs both channels
// - channel a overcurrent alert db7 read-only
// - channel b overcurrent alert db9 read-only
// - clear select picks zero, midscale or negative
// - outputs clamped until supplies stable, data written
// - channels start powered down, output grounded
// - clamp mode limits current, flag tracks fault
// - armed thermal shutdown sets alert, reset disarmed
// - clamp enable picks clamp or power-down
// - thermal shutdown arm bit, reset clear
`ifndef DPFC_REGS_SVH
`define DPFC_REGS_SVH

// =====================================================================
// frame layout
`define DPFC_FRAME_BITS 5'h18
`define DPFC_RW_BIT 23
`define DPFC_REG_MSB 21
`define DPFC_REG_LSB 19
`define DPFC_ADR_MSB 18
`define DPFC_ADR_LSB 16

// =====================================================================
// register select and channel address codes
`define DPFC_SEL_DAC 3'h0
`define DPFC_SEL_POWER 3'h2
`define DPFC_SEL_CTRL 3'h3
`define DPFC_ADR_CHAN_A 3'h0
`define DPFC_ADR_CHAN_B 3'h2
`define DPFC_ADR_BOTH 3'h4
`define DPFC_ADR_CTRL_OPT 3'h1

// =====================================================================
// power control bits
`define DPFC_PWR_PU_A 0
`define DPFC_PWR_PU_B 2
`define DPFC_PWR_VREF_POWER_ON 4
`define DPFC_PWR_TSD 5
`define DPFC_PWR_OC_A 7
`define DPFC_PWR_OC_B 9

// =====================================================================
// control option bits
`define DPFC_CTL_SDO_DIS 0
`define DPFC_CTL_CLR_SEL 1
`define DPFC_CTL_CLAMP 2
`define DPFC_CTL_TSD_ARM 3

// =====================================================================
// reset values
`define DPFC_RST_OFF 1'h0
`define DPFC_RST_CLAMP 1'h1

`endif

// >>> design/dpfc_sync.sv
// three-stage input synchroniser with agreement filter
// assumes raw inputs are asynchronous to clk_sys_i
`timescale 1ns/100ps
module dpfc_sync
   import dpfc_pkg::*;
#(
   parameter int WIDTH = 7
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // synchroniser carrier
   dpfc_sync_if.filter sif
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // =====================================================================
   // stage chain, first stage feeds only the second
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= sif.raw;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // a change counts once stages two and three agree
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic held;
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
         if (rst_i) begin
            held <= 1'b0;
         end else if (stage2[i] == stage3[i]) begin
            held <= stage3[i];
         end
      end
      assign sif.clean[i] = held;
   end
endmodule

// >>> design/dpfc_sync_if.sv
// carrier between the input synchroniser and the control block
// assumes both ends run on the system clock
`timescale 1ns/100ps
interface dpfc_sync_if #(parameter int WIDTH = 7);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] clean;
   modport filter (input raw, output clean);
   modport user (output raw, input clean);
endinterface
